//--- nvss_pkg.sv
// Constants, timing counts and carrier types for the store/recall sequencer.
// Assumes a single 100 MHz clock; all times are converted to cycles here.
package nvss_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock
   localparam int unsigned CLK_PERIOD_NS = 10;

   ////////////////////////////////////////////////////////////////////////////
   // Times as specified, each in its own unit
   localparam int unsigned POWERUP_RECALL_TIME_MS       = 20;
   localparam int unsigned SAVE_CYCLE_TIME_MS           = 8;
   localparam int unsigned RECALL_CYCLE_TIME_US         = 200;
   localparam int unsigned WRITE_COMPLETION_GRACE_NS    = 25;
   localparam int unsigned COMMAND_ACTION_TIME_US       = 100;
   localparam int unsigned SAVE_REQUEST_PULSE_MIN_NS    = 15;
   localparam int unsigned RELEASE_TO_ACTIVE_TIME_US    = 5;
   localparam int unsigned ACTIVE_HIGH_DRIVE_TIME_NS    = 500;

   ////////////////////////////////////////////////////////////////////////////
   // Cycle counts: longest times round down, least times round up
   localparam int unsigned POWERUP_RECALL_CYC =
      (POWERUP_RECALL_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned SAVE_CYCLE_CYC = (SAVE_CYCLE_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned RECALL_CYCLE_CYC = (RECALL_CYCLE_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned GRACE_CYC = WRITE_COMPLETION_GRACE_NS / CLK_PERIOD_NS;
   localparam int unsigned COMMAND_ACTION_CYC = (COMMAND_ACTION_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned SAVE_REQUEST_PULSE_MIN_CYC =
      (SAVE_REQUEST_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RELEASE_TO_ACTIVE_CYC =
      (RELEASE_TO_ACTIVE_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned ACTIVE_HIGH_DRIVE_CYC = ACTIVE_HIGH_DRIVE_TIME_NS / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic PF_SAVE_EN_RST = 1'h1;
   localparam logic DIRTY_RST      = 1'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Serial command codes
   typedef enum logic [1:0] {
      NVSS_CMD_SAVE    = 2'h0,
      NVSS_CMD_RECALL  = 2'h1,
      NVSS_CMD_PF_EN   = 2'h2,
      NVSS_CMD_PF_DIS  = 2'h3
   } nvss_cmd_code_t;

   // Decoded serial command, valid for one cycle
   typedef struct packed {
      logic           valid;
      nvss_cmd_code_t code;
   } nvss_cmd_t;

   // Array access permission
   typedef struct packed {
      logic en;
      logic wr_en;
   } nvss_arr_t;

   localparam nvss_arr_t ARR_RST = '{en: 1'h0, wr_en: 1'h0};

endpackage

//--- nvss_timer.sv
// One-shot down counter used for every timed phase of the sequencer.
// Assumes load is a single-cycle pulse and load_val is at least one.
`timescale 1ns/1ps
module nvss_timer #(
   parameter int unsigned W = 22
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rstn,
   // Control
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   // Expiry pulse
   output logic              done
);

   if (W < 2) begin : g_chk
      $error("nvss_timer: W must be at least 2");
   end

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic         run_ff;
   logic         nxt_run;
   logic         done_ff;
   logic         nxt_done;

   ////////////////////////////////////////////////////////////////////////////
   // Next count; a fresh load restarts even a running count
   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_run  = run_ff;
      nxt_done = 1'h0;
      if (load) begin
         nxt_cnt = load_val;
         nxt_run = 1'h1;
      end else if (run_ff) begin
         if (cnt_ff == {{(W-1){1'b0}}, 1'b1}) begin
            nxt_run  = 1'h0;
            nxt_done = 1'h1;
         end
         nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
      end
   end

   // Registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_ff  <= '0;
         run_ff  <= 1'h0;
         done_ff <= 1'h0;
      end else begin
         cnt_ff  <= nxt_cnt;
         run_ff  <= nxt_run;
         done_ff <= nxt_done;
      end
   end

   assign done = done_ff;

endmodule

//--- nvss_seq.sv
// Store/recall sequencer between the SRAM array and its nonvolatile cells.
// Assumes synchronous inputs, decoded serial commands and an external
// pull-up on the store/busy pin that the testbench resolves.
`timescale 1ns/1ps

module nvss_seq
   import nvss_pkg::*;
#(
   parameter int unsigned PUR_CYC    = nvss_pkg::POWERUP_RECALL_CYC,
   parameter int unsigned SAVE_CYC   = nvss_pkg::SAVE_CYCLE_CYC,
   parameter int unsigned RECALL_CYC = nvss_pkg::RECALL_CYCLE_CYC,
   parameter int unsigned CNT_W      = 22
) (
   // Clock and reset
   input  wire logic               ref_clk,
   input  wire logic               rstn,
   // Supply monitor: high while above the trip level
   input  wire logic               vcc_ok,
   // Store/busy pin
   input  wire logic               sb_in,
   output logic                    sb_out,
   output logic                    sb_oe,
   // Serial command port
   input  wire nvss_pkg::nvss_cmd_t cmd_in,
   output logic                    serial_lock,
   output logic                    pf_save_en,
   // Array side
   input  wire logic               arr_wr_req,
   output nvss_pkg::nvss_arr_t     arr_ctl,
   output logic                    dirty,
   // Nonvolatile cell control
   output logic                    nv_save,
   output logic                    nv_recall
);
   import nvss_pkg::*;

   if (CNT_W < 2 || PUR_CYC < 2 || SAVE_CYC < 2 || RECALL_CYC < 2 ||
       PUR_CYC >= (64'h1 << CNT_W) || SAVE_CYC >= (64'h1 << CNT_W) ||
       RECALL_CYC >= (64'h1 << CNT_W) || GRACE_CYC < 2 ||
       ACTIVE_HIGH_DRIVE_CYC < 2 || COMMAND_ACTION_CYC < 2) begin : g_chk
      $error("nvss_seq: counts do not fit the timer");
   end

   typedef enum logic [2:0] {
      ST_OFF, ST_PUR, ST_IDLE, ST_GRACE, ST_SAVE, ST_RECALL, ST_DRIVE_HI
   } nvss_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // State
   nvss_state_t      state_ff;
   nvss_state_t      nxt_state;
   nvss_arr_t        arr_ff;
   nvss_arr_t        nxt_arr;
   logic             dirty_ff;
   logic             nxt_dirty;
   logic             pf_en_ff;
   logic             nxt_pf_en;
   logic             lock_ff;
   logic             nxt_lock;
   logic             sb_out_ff;
   logic             nxt_sb_out;
   logic             sb_oe_ff;
   logic             nxt_sb_oe;
   logic             save_ff;
   logic             nxt_save;
   logic             recall_ff;
   logic             nxt_recall;
   logic             tmr_load;
   logic [CNT_W-1:0] tmr_val;
   logic             tmr_done;
   logic             pin_low;
   logic             cmd_take;
   logic             wr_taken;

   // Only an outside driver counts; our own low drive must not re-trigger
   // A host low during our high drive still counts and still shuts the array
   assign pin_low  = !sb_in && !(sb_oe_ff && !sb_out_ff);
   // Refused while locked or busy; the host sees no answer
   assign cmd_take = cmd_in.valid && !lock_ff && state_ff == ST_IDLE && vcc_ok;
   assign wr_taken = arr_wr_req && arr_ff.wr_en;

   ////////////////////////////////////////////////////////////////////////////
   // Phase timer
   nvss_timer #(.W(CNT_W)) u_timer (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer next state; timer loads with count-1 so a phase lasts count cycles
   always_comb begin
      nxt_state = state_ff;
      tmr_load  = 1'h0;
      tmr_val   = '0;
      nxt_pf_en = pf_en_ff;
      case (state_ff)
         ST_OFF: begin
            if (vcc_ok) begin
               nxt_state = ST_PUR;
               tmr_load  = 1'h1;
               tmr_val   = CNT_W'(PUR_CYC - 1);
            end
         end
         ST_PUR, ST_RECALL: begin
            if (!vcc_ok) begin
               nxt_state = ST_OFF;
            end else if (tmr_done) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_IDLE, ST_DRIVE_HI: begin
            if (!vcc_ok || pin_low) begin
               // Clean array: nothing to save
               if (dirty_ff && (pin_low || pf_en_ff)) begin
                  nxt_state = ST_GRACE;
                  tmr_load  = 1'h1;
                  tmr_val   = CNT_W'(GRACE_CYC - 1);
               end else if (!vcc_ok) begin
                  nxt_state = ST_OFF;
               end else begin
                  nxt_state = ST_IDLE;
               end
            end else if (cmd_take) begin
               // Acted on in the next cycle, far inside the allowed time
               case (cmd_in.code)
                  NVSS_CMD_SAVE: begin
                     nxt_state = ST_SAVE;
                     tmr_load  = 1'h1;
                     tmr_val   = CNT_W'(SAVE_CYC - 1);
                  end
                  NVSS_CMD_RECALL: begin
                     nxt_state = ST_RECALL;
                     tmr_load  = 1'h1;
                     tmr_val   = CNT_W'(RECALL_CYC - 1);
                  end
                  NVSS_CMD_PF_EN: begin
                     nxt_pf_en = 1'h1;
                  end
                  default: begin
                     nxt_pf_en = 1'h0;
                  end
               endcase
            end else if (state_ff == ST_DRIVE_HI && tmr_done) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_GRACE: begin
            if (tmr_done) begin
               nxt_state = ST_SAVE;
               tmr_load  = 1'h1;
               tmr_val   = CNT_W'(SAVE_CYC - 1);
            end
         end
         ST_SAVE: begin
            // Save runs on held charge even if the supply falls
            if (tmr_done) begin
               if (!vcc_ok) begin
                  nxt_state = ST_OFF;
               end else begin
                  nxt_state = ST_DRIVE_HI;
                  tmr_load  = 1'h1;
                  tmr_val   = CNT_W'(ACTIVE_HIGH_DRIVE_CYC - 1);
               end
            end
         end
         default: begin
            nxt_state = ST_OFF;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs derived from the next state so they change with it
   always_comb begin
      nxt_arr.en    = (nxt_state == ST_IDLE || nxt_state == ST_DRIVE_HI) &&
                      vcc_ok && !pin_low;
      nxt_arr.wr_en = nxt_arr.en || nxt_state == ST_GRACE;
      nxt_lock      = !(nxt_state == ST_IDLE || nxt_state == ST_DRIVE_HI);
      nxt_save      = nxt_state == ST_SAVE;
      nxt_recall    = nxt_state == ST_PUR || nxt_state == ST_RECALL;
      nxt_sb_oe     = nxt_state == ST_GRACE || nxt_state == ST_SAVE ||
                      nxt_state == ST_DRIVE_HI;
      nxt_sb_out    = nxt_state == ST_DRIVE_HI;
      // A write in the clearing cycle keeps the flag set
      nxt_dirty     = dirty_ff;
      if ((nxt_save && !save_ff) || (nxt_recall && !recall_ff)) begin
         nxt_dirty = 1'h0;
      end
      if (wr_taken) begin
         nxt_dirty = 1'h1;
      end
   end

   // Registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff  <= ST_OFF;
         arr_ff    <= ARR_RST;
         dirty_ff  <= DIRTY_RST;
         pf_en_ff  <= PF_SAVE_EN_RST;
         lock_ff   <= 1'h1;
         sb_out_ff <= 1'h0;
         sb_oe_ff  <= 1'h0;
         save_ff   <= 1'h0;
         recall_ff <= 1'h0;
      end else begin
         state_ff  <= nxt_state;
         arr_ff    <= nxt_arr;
         dirty_ff  <= nxt_dirty;
         pf_en_ff  <= nxt_pf_en;
         lock_ff   <= nxt_lock;
         sb_out_ff <= nxt_sb_out;
         sb_oe_ff  <= nxt_sb_oe;
         save_ff   <= nxt_save;
         recall_ff <= nxt_recall;
      end
   end

   assign arr_ctl     = arr_ff;
   assign dirty       = dirty_ff;
   assign pf_save_en  = pf_en_ff;
   assign serial_lock = lock_ff;
   assign sb_out      = sb_out_ff;
   assign sb_oe       = sb_oe_ff;
   assign nv_save     = save_ff;
   assign nv_recall   = recall_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Helper: age of the power-up recall
   logic [CNT_W:0] pur_age_ff;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pur_age_ff <= '0;
      end else if (state_ff == ST_PUR) begin
         pur_age_ff <= pur_age_ff + {{CNT_W{1'b0}}, 1'b1};
      end else begin
         pur_age_ff <= '0;
      end
   end

   a_pur_bound: assert property (@(posedge ref_clk) disable iff (!rstn)
      pur_age_ff <= (CNT_W+1)'(PUR_CYC)) else $error("power-up recall too long");

   a_skip_clean: assert property (@(posedge ref_clk) disable iff (!rstn)
      (state_ff == ST_IDLE && !dirty_ff && !wr_taken && (!vcc_ok || pin_low))
      |=> !save_ff && state_ff != ST_GRACE) else $error("save started on clean array");

   a_grace_window: assert property (@(posedge ref_clk) disable iff (!rstn)
      $rose(state_ff == ST_GRACE) |-> arr_ff.wr_en [*2] ##1 (!arr_ff.wr_en && save_ff))
      else $error("write grace window wrong");

   a_busy_block: assert property (@(posedge ref_clk) disable iff (!rstn)
      (save_ff || recall_ff) |-> (!arr_ff.en && !arr_ff.wr_en))
      else $error("array open during nv cycle");

   a_low_supply: assert property (@(posedge ref_clk) disable iff (!rstn)
      !vcc_ok |=> !arr_ff.en) else $error("array open below trip level");

   a_cmd_action: assert property (@(posedge ref_clk) disable iff (!rstn)
      (cmd_take && !pin_low && cmd_in.code == NVSS_CMD_SAVE) |=> (save_ff && lock_ff))
      else $error("save command not acted on");

   a_cmd_pf_dis: assert property (@(posedge ref_clk) disable iff (!rstn)
      (cmd_take && !pin_low && cmd_in.code == NVSS_CMD_PF_DIS) |=> !pf_en_ff)
      else $error("power-fail disable not acted on");

   a_serial_lock: assert property (@(posedge ref_clk) disable iff (!rstn)
      (recall_ff || save_ff) |-> lock_ff)
      else $error("serial port open during recall");

   a_pin_block: assert property (@(posedge ref_clk) disable iff (!rstn)
      pin_low |=> !arr_ff.en) else $error("array open while pin held low");

   a_ready_after: assert property (@(posedge ref_clk) disable iff (!rstn)
      $rose(sb_out_ff) |-> ##[1:500] (arr_ff.en || !vcc_ok || !sb_in))
      else $error("array not ready after pin high");

   a_high_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
      $rose(sb_out_ff) |-> ##[1:50] !(sb_oe_ff && sb_out_ff))
      else $error("pin driven high too long");

   a_save_low: assert property (@(posedge ref_clk) disable iff (!rstn)
      save_ff |-> (sb_oe_ff && !sb_out_ff)) else $error("pin not low during save");

endmodule

//--- nvss_host.sv
// Host-side model of the sequencer's far side: supply, serial commands,
// the store/busy pin with its pull-up, and array write attempts.
// Assumes one shared clock; every drive lands by NBA at a rising edge.
`timescale 1ns/1ps
module nvss_host
   import nvss_pkg::*;
(
   // Clock
   input  wire logic           ref_clk,
   // Pin drive from the sequencer
   input  wire logic           sb_out,
   input  wire logic           sb_oe,
   // Stimulus
   output logic                vcc_ok,
   output logic                sb_in,
   output nvss_pkg::nvss_cmd_t cmd_in,
   output logic                arr_wr_req
);
   import nvss_pkg::*;

   logic host_low;

   // Known levels before the first edge
   initial begin
      vcc_ok     = 1'h0;
      host_low   = 1'h0;
      cmd_in     = '0;
      arr_wr_req = 1'h0;
   end

   // Wired pin: any low driver wins, pull-up when nobody drives
   assign sb_in = ~(host_low | (sb_oe & ~sb_out));

   ////////////////////////////////////////////////////////////////////////////
   // Drivers, each launched just after a rising edge
   task automatic vcc_up();
      @(posedge ref_clk);
      vcc_ok <= 1'h1;
   endtask

   task automatic vcc_down();
      @(posedge ref_clk);
      vcc_ok <= 1'h0;
   endtask

   // Callers hold the pin low two cycles or more, past the minimum pulse
   task automatic pin_pull();
      @(posedge ref_clk);
      host_low <= 1'h1;
   endtask

   task automatic pin_free();
      @(posedge ref_clk);
      host_low <= 1'h0;
   endtask

   // One-cycle write attempt
   task automatic wr_pulse();
      @(posedge ref_clk);
      arr_wr_req <= 1'h1;
      @(posedge ref_clk);
      arr_wr_req <= 1'h0;
   endtask

   // Held write attempt, ended by wr_off
   task automatic wr_on();
      @(posedge ref_clk);
      arr_wr_req <= 1'h1;
   endtask

   task automatic wr_off();
      @(posedge ref_clk);
      arr_wr_req <= 1'h0;
   endtask

   // Fire and forget: no answer is awaited on the port after a command
   task automatic send_cmd(input nvss_cmd_code_t c);
      @(posedge ref_clk);
      cmd_in <= '{valid: 1'h1, code: c};
      @(posedge ref_clk);
      cmd_in <= '{valid: 1'h0, code: c};
   endtask
endmodule

//--- tb.sv
// Self-checking bench for the store/recall sequencer with shortened counts.
// Assumes the host model drives every input except clock and reset.
`timescale 1ns/1ps
module tb;
   import nvss_pkg::*;

   localparam int unsigned T_PUR = 20;
   localparam int unsigned T_SAVE = 10;
   localparam int unsigned T_REC = 8;
   localparam int unsigned HI_DRIVE = ACTIVE_HIGH_DRIVE_CYC;

   typedef struct packed {
      nvss_cmd_code_t code;
      logic           pf;
      logic           save;
      logic           rec;
   } nvss_row_t;

   logic      ref_clk, rstn, vcc_ok, sb_in, sb_out, sb_oe, serial_lock, pf_save_en;
   logic      arr_wr_req, dirty, nv_save, nv_recall;
   nvss_cmd_t cmd_in;
   nvss_arr_t arr_ctl;
   int        fail_count, checked, n;
   nvss_row_t rows [4] = '{'{NVSS_CMD_PF_DIS, 1'h0, 1'h0, 1'h0},
                           '{NVSS_CMD_PF_EN, 1'h1, 1'h0, 1'h0},
                           '{NVSS_CMD_RECALL, 1'h1, 1'h0, 1'h1},
                           '{NVSS_CMD_SAVE, 1'h1, 1'h1, 1'h0}};

   nvss_seq #(.PUR_CYC(T_PUR), .SAVE_CYC(T_SAVE), .RECALL_CYC(T_REC), .CNT_W(22)) i_dut (
      .ref_clk(ref_clk), .rstn(rstn), .vcc_ok(vcc_ok), .sb_in(sb_in), .sb_out(sb_out),
      .sb_oe(sb_oe), .cmd_in(cmd_in), .serial_lock(serial_lock), .pf_save_en(pf_save_en),
      .arr_wr_req(arr_wr_req), .arr_ctl(arr_ctl), .dirty(dirty), .nv_save(nv_save),
      .nv_recall(nv_recall));

   nvss_host i_host (.ref_clk(ref_clk), .sb_out(sb_out), .sb_oe(sb_oe), .vcc_ok(vcc_ok),
      .sb_in(sb_in), .cmd_in(cmd_in), .arr_wr_req(arr_wr_req));

   // 100 MHz clock
   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic chk(input logic seen, input logic exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Sample just after the edge so its updates have landed
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask

   // Wait out a save or recall; array and port must stay shut throughout
   task automatic wait_nv();
      n = 0;
      while ((nv_save === 1'h1 || nv_recall === 1'h1) && n < 200) begin
         chk(arr_ctl.en | arr_ctl.wr_en, 1'h0);
         chk(serial_lock, 1'h1);
         if (nv_save === 1'h1) begin
            chk(sb_oe & ~sb_out, 1'h1);
            chk(dirty, 1'h0);
         end
         tick(1);
         n++;
      end
      chk(n < 200, 1'h1);
   endtask

   // Short high drive of the pin, then release to the pull-up
   task automatic after_save();
      chk(arr_ctl.en, 1'h1);
      n = 0;
      while (sb_oe === 1'h1 && n < 100) begin
         chk(sb_out, 1'h1);
         tick(1);
         n++;
      end
      chk(n > 0 && n <= HI_DRIVE, 1'h1);
      chk(sb_in, 1'h1);
   endtask

   task automatic power_up();
      logic rec_seen;
      rec_seen = 1'h0;
      n = 0;
      i_host.vcc_up();
      while (arr_ctl.en !== 1'h1 && n < 100) begin
         tick(1);
         n++;
         if (nv_recall === 1'h1) rec_seen = 1'h1;
      end
      chk(rec_seen, 1'h1);
      chk(n <= T_PUR + 2, 1'h1);
      chk(serial_lock, 1'h0);
   endtask

   task automatic report_and_stop();
      $display("Comparisons: %0d, mismatches: %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Cut a hang short well past the expected run length
   initial begin
      #100000;
      fail_count++;
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rstn = 1'h0;
      fail_count = 0;
      checked = 0;
      tick(1);
      chk(arr_ctl.en | sb_oe | nv_save | nv_recall | dirty, 1'h0);
      chk(serial_lock & pf_save_en, 1'h1);
      repeat (8) @(posedge ref_clk);
      rstn <= 1'h1;
      power_up();
      // Every command once; save and recall must lock out a following one
      foreach (rows[i]) begin
         i_host.send_cmd(rows[i].code);
         #1;
         chk(pf_save_en, rows[i].pf);
         chk(nv_save, rows[i].save);
         chk(nv_recall, rows[i].rec);
         if (rows[i].save | rows[i].rec) begin
            i_host.send_cmd(NVSS_CMD_PF_DIS);
            #1;
            chk(pf_save_en, 1'h1);
            wait_nv();
            if (rows[i].save) after_save();
         end
      end
      // Pin pulled low with a clean array: no save, array shut while low
      i_host.pin_pull();
      tick(2);
      chk(nv_save | sb_oe, 1'h0);
      chk(arr_ctl.en, 1'h0);
      i_host.pin_free();
      tick(2);
      chk(arr_ctl.en, 1'h1);
      // Dirty array, pin request: two-cycle write grace, then save
      i_host.wr_pulse();
      tick(1);
      chk(dirty, 1'h1);
      i_host.pin_pull();
      tick(1);
      chk(arr_ctl.wr_en, 1'h1);
      chk(arr_ctl.en, 1'h0);
      i_host.pin_free();
      #1;
      chk(arr_ctl.wr_en, 1'h1);
      tick(1);
      chk(nv_save, 1'h1);
      chk(arr_ctl.wr_en, 1'h0);
      i_host.wr_on();
      #1;
      wait_nv();
      after_save();
      i_host.wr_off();
      // Supply fails with a dirty array: grace, save, then off
      i_host.vcc_down();
      tick(1);
      chk(arr_ctl.en, 1'h0);
      chk(arr_ctl.wr_en, 1'h1);
      tick(2);
      chk(nv_save, 1'h1);
      wait_nv();
      chk(arr_ctl.en, 1'h0);
      // Power-fail save disabled: a dirty array is not saved
      power_up();
      i_host.send_cmd(NVSS_CMD_PF_DIS);
      i_host.wr_pulse();
      i_host.vcc_down();
      tick(4);
      chk(nv_save | sb_oe, 1'h0);
      // Enabled again but clean: no save either
      power_up();
      i_host.send_cmd(NVSS_CMD_PF_EN);
      i_host.vcc_down();
      tick(4);
      chk(nv_save | sb_oe, 1'h0);
      // Reset in mid-save drops everything; its release recalls afresh
      power_up();
      i_host.send_cmd(NVSS_CMD_PF_DIS);
      i_host.send_cmd(NVSS_CMD_SAVE);
      tick(2);
      rstn <= 1'h0;
      tick(1);
      chk(nv_save | sb_oe | arr_ctl.en, 1'h0);
      chk(pf_save_en & serial_lock, 1'h1);
      rstn <= 1'h1;
      power_up();
      chk(dirty, 1'h0);
      report_and_stop();
   end
endmodule
